// [pkg/qdr_pkg.sv]
// Constants and types shared by the quad converter readback and reset host controller.
package qdr_pkg;
    localparam int DATA_W       = 12;
    localparam int CLK_PERIOD_NS = 8;
    // Data valid after read strobe, full temperature range.
    localparam int T_DV_NS      = 180;
    // Data float after read strobe release, full temperature range.
    localparam int T_DF_NS      = 75;
    // Reset pulse width, full temperature range.
    localparam int T_RW_NS      = 100;
    // Least times round up to whole cycles.
    localparam int DV_CYC = (T_DV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DF_CYC = (T_DF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RW_CYC = (T_RW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W  = 6;
    // Slice select codes, active low: bit0 low nibble, bit1 mid nibble, bit2 high nibble.
    localparam logic [2:0] SLICE_ALL  = 3'h0;
    localparam logic [2:0] SLICE_NONE = 3'h7;
    localparam logic [2:0] SLICE_MODE = 3'h4;
    typedef enum logic [1:0] {
        QDR_IDLE,
        QDR_READ,
        QDR_FLOAT,
        QDR_RESET
    } qdr_state_t;
endpackage

// [hw/qdr_host.sv]
// Host controller that reads back codes and mode word and pulses the converter reset.
`timescale 1ns/1ps
`default_nettype none
module qdr_host (
    // Clock and reset.
    input  wire logic                     i_clk,
    input  wire logic                     i_reset_n,
    // User request side.
    input  wire logic                     i_rd_code,
    input  wire logic                     i_rd_mode,
    input  wire logic                     i_do_reset,
    input  wire logic [1:0]               i_channel,
    input  wire logic [2:0]               i_slice_n,
    output logic                          o_busy,
    output logic                          o_done,
    output logic [qdr_pkg::DATA_W-1:0]    o_rdata,
    // Device pins.
    input  wire logic [qdr_pkg::DATA_W-1:0] i_dev_data,
    output logic                          o_channel_select_0,
    output logic                          o_channel_select_1,
    output logic                          o_slice_select_0_n,
    output logic                          o_slice_select_1_n,
    output logic                          o_slice_select_2_n,
    output logic                          o_mode_word_strobe_n,
    output logic                          o_pass_through_strobe_n,
    output logic                          o_read_n,
    output logic                          o_chip_select_n,
    output logic                          o_dev_reset_n
);
    import qdr_pkg::*;

    // Timing budget of one access, in clock cycles of the host clock.
    // A read holds the read strobe and chip select low for the whole data
    // valid time, rounded up to whole cycles, and samples the data port at
    // the last edge of that window. The device needs no address set-up or
    // hold time, so the selects are set in the same cycle the strobes fall.
    // After the strobes rise the controller waits the data float time before
    // it reports done, so that a following access can never see the device
    // still driving the port from the previous read.
    // A reset pulse is held for the full-temperature minimum width, rounded
    // up, which leaves a few nanoseconds of margin at this clock rate.
    // The same pulse is issued after our own reset, so the device leaves
    // power-up from a known state rather than a stray read or write
    // condition. Its end is reported through done like any other operation,
    // which tells the user when the port may first be used.
    // Limitation: requests that arrive while busy are dropped without notice;
    // the user must watch busy or done before asking again.
    // Trade-off: the fixed counts assume the worst case over temperature,
    // which costs a few cycles per access at room temperature but needs no
    // calibration and no knowledge of the part grade.

    // True when a wait counter has run out; shared by every timed state.
    function automatic logic cnt_expired(input logic [CNT_W-1:0] cnt);
        return (cnt == '0);
    endfunction

    // One step down of a wait counter; callers only step a non-zero count.
    function automatic logic [CNT_W-1:0] cnt_step(input logic [CNT_W-1:0] cnt);
        return cnt - 1'b1;
    endfunction

    typedef struct packed {
        qdr_state_t          st;
        logic [CNT_W-1:0]    cnt;
        logic                busy;
        logic                done;
        logic [DATA_W-1:0]   rdata;
        logic [1:0]          chan;
        logic [2:0]          slice_n;
        logic                mode_n;
        logic                rd_n;
        logic                cs_n;
        logic                rst_n;
    } qdr_regs_t;

    qdr_regs_t r_q;
    qdr_regs_t r_d;

    // Next-state logic; one request at a time, reset has priority over reads.
    always_comb begin
        r_d      = r_q;
        r_d.done = 1'b0;
        case (r_q.st)
            QDR_IDLE: begin
                if (i_do_reset) begin
                    r_d.st    = QDR_RESET;
                    r_d.rst_n = 1'b0;
                    r_d.cnt   = CNT_W'(RW_CYC - 1);
                    r_d.busy  = 1'b1;
                end else if (i_rd_mode) begin
                    r_d.st      = QDR_READ;
                    r_d.mode_n  = 1'b0;
                    r_d.slice_n = SLICE_MODE;
                    r_d.rd_n    = 1'b0;
                    r_d.cs_n    = 1'b0;
                    r_d.cnt     = CNT_W'(DV_CYC - 1);
                    r_d.busy    = 1'b1;
                end else if (i_rd_code) begin
                    r_d.st      = QDR_READ;
                    r_d.chan    = i_channel;
                    r_d.slice_n = i_slice_n;
                    r_d.rd_n    = 1'b0;
                    r_d.cs_n    = 1'b0;
                    r_d.cnt     = CNT_W'(DV_CYC - 1);
                    r_d.busy    = 1'b1;
                end
            end
            QDR_READ: begin
                // Wait the data valid time before sampling the port.
                // Sampling earlier would capture a half-settled word.
                if (cnt_expired(r_q.cnt)) begin
                    r_d.rdata   = i_dev_data;
                    r_d.rd_n    = 1'b1;
                    r_d.cs_n    = 1'b1;
                    r_d.cnt     = CNT_W'(DF_CYC - 1);
                    r_d.st      = QDR_FLOAT;
                end else begin
                    r_d.cnt = cnt_step(r_q.cnt);
                end
            end
            QDR_FLOAT: begin
                // Hold off the next access until the device has released the bus.
                // The selects stay put meanwhile so the device sees no new address.
                if (cnt_expired(r_q.cnt)) begin
                    r_d.mode_n  = 1'b1;
                    r_d.slice_n = SLICE_NONE;
                    r_d.busy    = 1'b0;
                    r_d.done    = 1'b1;
                    r_d.st      = QDR_IDLE;
                end else begin
                    r_d.cnt = cnt_step(r_q.cnt);
                end
            end
            QDR_RESET: begin
                // Both user pulses and the power-up pulse end here.
                // Release only after the full width has been counted.
                if (cnt_expired(r_q.cnt)) begin
                    r_d.rst_n = 1'b1;
                    r_d.busy  = 1'b0;
                    r_d.done  = 1'b1;
                    r_d.st    = QDR_IDLE;
                end else begin
                    r_d.cnt = cnt_step(r_q.cnt);
                end
            end
            default: r_d.st = QDR_IDLE;
        endcase
    end

    // State register; the device reset is held low while our own reset is active,
    // which gives it a power-on reset.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            r_q         <= '0;
            r_q.st      <= QDR_IDLE;
            r_q.slice_n <= SLICE_NONE;
            r_q.mode_n  <= 1'b1;
            r_q.rd_n    <= 1'b1;
            r_q.cs_n    <= 1'b1;
            r_q.rst_n   <= 1'b0;
            // Leave our reset through a counted device pulse, so the device
            // reset is released again even if no user pulse is ever asked for.
            r_q.st      <= QDR_RESET;
            r_q.cnt     <= CNT_W'(RW_CYC - 1);
            r_q.busy    <= 1'b1;
        end else begin
            r_q <= r_d;
        end
    end

    // Pin and status outputs straight from flip-flops, except the pass-through strobe, which is tied high.
    assign o_busy                  = r_q.busy;
    assign o_done                  = r_q.done;
    assign o_rdata                 = r_q.rdata;
    assign o_channel_select_0      = r_q.chan[0];
    assign o_channel_select_1      = r_q.chan[1];
    assign o_slice_select_0_n      = r_q.slice_n[0];
    assign o_slice_select_1_n      = r_q.slice_n[1];
    assign o_slice_select_2_n      = r_q.slice_n[2];
    assign o_mode_word_strobe_n    = r_q.mode_n;
    assign o_pass_through_strobe_n = 1'b1;
    assign o_read_n                = r_q.rd_n;
    assign o_chip_select_n         = r_q.cs_n;
    assign o_dev_reset_n           = r_q.rst_n;
endmodule
`default_nettype wire

// [bench/qdr_dev_model.sv]
// Behavioural model of the quad converter readback port and reset pin.
`timescale 1ns/1ps
`default_nettype none
module qdr_dev_model (
    input  wire logic [1:0]  i_ch,
    input  wire logic [2:0]  i_slice_n,
    input  wire logic        i_mode_n, i_read_n, i_cs_n, i_rst_n,
    output logic      [11:0] o_data
);
    logic [11:0] code [4];
    logic [7:0]  mode;
    logic [11:0] word;
    // Codes appear once the device reset pin first rises, as if written earlier.
    initial begin
        @(posedge i_rst_n);
        for (int i = 0; i < 4; i++) code[i] = 12'h123 + 12'(i) * 12'h111;
        mode = 8'h5a;
    end
    // Reset acts at once on the falling edge, whatever else is going on.
    always @(negedge i_rst_n) begin
        for (int i = 0; i < 4; i++) code[i] = 12'h000;
        mode = 8'h00;
    end
    // Code or mode word is chosen by the mode strobe.
    always_comb word = i_mode_n ? code[i_ch] : {4'h0, mode};
    // Unselected nibbles float, shown as the inverse so stale data cannot match.
    for (genvar k = 0; k < 3; k++) begin : g_nib
        assign o_data[4*k+:4] = (!i_read_n && !i_cs_n && !i_slice_n[k]) ?
                                word[4*k+:4] : ~word[4*k+:4];
    end
endmodule
`default_nettype wire

// [bench/qdr_host_properties.sv]
// Timing checks on the host controller pins.
`timescale 1ns/1ps
`default_nettype none
module qdr_host_properties (
    input wire logic i_clk, i_reset_n, o_done, o_busy, o_read_n, o_chip_select_n,
    input wire logic o_slice_select_0_n, o_slice_select_1_n, o_slice_select_2_n,
    input wire logic o_mode_word_strobe_n, o_pass_through_strobe_n, o_dev_reset_n,
    input wire logic o_channel_select_0, o_channel_select_1,
    input wire logic [11:0] i_dev_data, o_rdata
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    property p_pair; o_read_n == o_chip_select_n; endproperty
    a_pair: assert property (p_pair) else $error("read and select split");
    property p_dv; $fell(o_read_n) |-> ##22 !o_read_n ##1 o_read_n; endproperty
    a_dv: assert property (p_dv) else $error("read strobe width");
    property p_df; $rose(o_read_n) |-> !o_done [*5] ##1 !o_done [*5] ##1 o_done; endproperty
    a_df: assert property (p_df) else $error("float wait");
    property p_rw; $fell(o_dev_reset_n) |-> ##12 !o_dev_reset_n ##1 o_dev_reset_n; endproperty
    a_rw: assert property (p_rw) else $error("reset pulse width");
    property p_mode; !o_mode_word_strobe_n |-> o_dev_reset_n &&
        {o_slice_select_2_n, o_slice_select_1_n, o_slice_select_0_n} == 3'h4; endproperty
    a_mode: assert property (p_mode) else $error("mode read pins");
    property p_tr; o_pass_through_strobe_n; endproperty
    a_tr: assert property (p_tr) else $error("pass-through strobe low");
    property p_addr; !o_read_n && !$past(o_read_n) |-> $stable({o_channel_select_0,
        o_channel_select_1, o_slice_select_0_n, o_mode_word_strobe_n}); endproperty
    a_addr: assert property (p_addr) else $error("address moved");
    property p_cap; $rose(o_read_n) |-> o_rdata == $past(i_dev_data); endproperty
    a_cap: assert property (p_cap) else $error("data capture");
    c_read: cover property ($rose(o_read_n) && o_mode_word_strobe_n);
    c_mode: cover property (!o_mode_word_strobe_n);
    c_rst: cover property ($rose(o_dev_reset_n));
endmodule
bind qdr_host qdr_host_properties u_props (.i_clk(i_clk), .i_reset_n(i_reset_n), .*);
`default_nettype wire

// [bench/quad_dac_readback_and_reset_bench.sv]
// Self-checking bench for the host controller against the converter model.
`timescale 1ns/1ps
`default_nettype none
module quad_dac_readback_and_reset_bench;
    import qdr_pkg::*;
    logic i_clk = 0, i_reset_n = 0, i_rd_code = 0, i_rd_mode = 0, i_do_reset = 0;
    logic [1:0] i_channel = 0;
    logic [2:0] i_slice_n = SLICE_ALL;
    wire logic [11:0] dd, rdata;
    wire logic done, busy, c0, c1, s0, s1, s2, ms, tr, rd, cs, dr;
    int errors = 0, checks = 0, cyc = 0, cnt;
    qdr_host dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_rd_code(i_rd_code),
        .i_rd_mode(i_rd_mode), .i_do_reset(i_do_reset), .i_channel(i_channel),
        .i_slice_n(i_slice_n), .o_busy(busy), .o_done(done), .o_rdata(rdata),
        .i_dev_data(dd), .o_channel_select_0(c0), .o_channel_select_1(c1),
        .o_slice_select_0_n(s0), .o_slice_select_1_n(s1), .o_slice_select_2_n(s2),
        .o_mode_word_strobe_n(ms), .o_pass_through_strobe_n(tr), .o_read_n(rd),
        .o_chip_select_n(cs), .o_dev_reset_n(dr));
    qdr_dev_model u_dev (.i_ch({c1, c0}), .i_slice_n({s2, s1, s0}), .i_mode_n(ms),
        .i_read_n(rd), .i_cs_n(cs), .i_rst_n(dr), .o_data(dd));
    // Free-running clock with a cycle ceiling so a hang still ends the run.
    initial forever #4 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 1000) begin
            errors++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One request pulse, then count cycles with read strobe or device reset low until done.
    task automatic op(input logic c, input logic m, input logic r, input logic [1:0] ch);
        @(negedge i_clk);
        {i_rd_code, i_rd_mode, i_do_reset, i_channel} = {c, m, r, ch};
        @(negedge i_clk);
        {i_rd_code, i_rd_mode, i_do_reset} = 3'h0;
        cnt = 0;
        while (done !== 1'b1 && cnt < 60) begin
            cnt += int'(!(rd & dr));
            @(negedge i_clk);
        end
        chk({11'h0, done}, 12'h001);
    endtask
    task automatic report_and_stop();
        if (errors == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Reads every channel, the mode word, pulses reset, then reads cleared contents.
    initial begin
        repeat (2) @(negedge i_clk);
        i_reset_n = 1;
        while (busy !== 1'b0) @(negedge i_clk);
        for (int i = 0; i < 4; i++) begin
            op(1, 0, 0, 2'(i));
            chk(rdata, 12'h123 + 12'(i) * 12'h111);
            chk(12'(cnt), 12'(DV_CYC));
        end
        op(0, 1, 0, 2'h0);
        chk({4'h0, rdata[7:0]}, 12'h05a);
        op(0, 0, 1, 2'h0);
        chk(12'(cnt), 12'(RW_CYC));
        op(1, 0, 0, 2'h2);
        chk(rdata, 12'h000);
        op(0, 1, 0, 2'h0);
        chk({4'h0, rdata[7:0]}, 12'h000);
        report_and_stop();
    end
endmodule
`default_nettype wire
